/* File: pet_timer.sv */
// Prescaled event timer top with APB register slave.
// How it works
// [RQ1] Eleven-bit prescaler, cleared to zero by reset.
// [RQ2] Prescaler halts only in reset or stop.
// [RQ3] Internal clocks are prescaler taps, except event.
// [RQ4] Eight-bit counter: free-run, reload, event counting.
// [RQ5] Counter starts from software load value.
// [RQ6] Increment per tick; overflow past full count.
// [RQ7] Overflow continues from load value or zero.
// [RQ8] Overflow sets flag; software or reset clears.
// [RQ9] Mode field picks reload, source and ratio.
// [RQ10] Top bit reload; low bits pick period.
// [RQ11] Mode register four bits, write-only, reset zero.
// [RQ12] Mode write takes effect two cycles later.
// [RQ13] Software loads start value after mode settles.
// [RQ14] Event source counts pins, same overflow behaviour.
// [RQ15] Pin serves events only when function selected.
// [RQ16] Edge select: rising, falling or both.
// [RQ17] Source keeps over two cycles fall-to-rise.
// [RQ18] Count reads, load writes share two addresses.
// [RQ19] Low nibble first; high write loads counter.
// [RQ20] High read latches matching low nibble.
// [RQ21] Edge register two bits, write-only, reset zero.
// [RQ22] Event pin synchronised before edge detection.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
module pet_timer
  import pet_pkg::*;
#(
  parameter int COUNT_W = PET_COUNT_W
) (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Event pin.
  input  wire logic        event_count_input,
  // Status.
  output logic             timer_overflow_flag,
  output logic             irq_pin_enable
);

  typedef struct packed {
    logic [3:0]         mode_wr_r;
    logic [3:0]         mode_act_r;
    logic [1:0]         mode_dly_r;
    logic [1:0]         edge_r;
    logic [3:0]         pin_r;
    logic [3:0]         load_low_r;
    logic [3:0]         load_high_r;
    logic [COUNT_W-1:0] cnt_r;
    logic [3:0]         low_latch_r;
    logic               flag_r;
    logic               stop_r;
    logic [31:0]        prdata_r;
    logic               pready_r;
    logic               pslverr_r;
    logic               irq_en_r;
  } pet_state_t;

  pet_state_t st_r;
  pet_state_t st_nxt;

  logic [PET_PRESCALE_W-1:0] ps_tick;
  logic                      ev_pulse;

  // Turns a byte address into a register index; misaligned gives all ones.
  function automatic logic [11:0] pet_index(input logic [13:0] addr);
    if (addr[1:0] != 2'b00) begin
      return 12'hfff;
    end
    return addr[13:2];
  endfunction : pet_index

  // Maps a clock-select code to the prescaler tap index.
  function automatic int pet_tap(input logic [2:0] sel);
    case (sel)
      3'h0:    return 10;
      3'h1:    return 8;
      3'h2:    return 6;
      3'h3:    return 4;
      3'h4:    return 2;
      3'h5:    return 1;
      default: return 0;
    endcase
  endfunction : pet_tap

  pet_prescaler #(
    .WIDTH (PET_PRESCALE_W)
  ) u_prescaler (
    .pclk      (pclk),
    .presetn   (presetn),
    .stop_mode (st_r.stop_r),
    .count     (),
    .tick      (ps_tick)
  );

  pet_event_sync u_event_sync (
    .pclk        (pclk),
    .presetn     (presetn),
    .pin         (event_count_input),
    .enable      (st_r.pin_r[PET_PIN_EVENT_BIT]),
    .edge_sel    (st_r.edge_r),
    .event_pulse (ev_pulse)
  );

  logic [11:0] idx;
  logic        access;
  logic        count_tick;
  logic        hi_load;

  always_comb begin
    st_nxt     = st_r;
    idx        = pet_index(paddr);
    access     = psel && penable && !st_r.pready_r;
    hi_load    = 1'b0;
    count_tick = 1'b0;

    st_nxt.pready_r  = 1'b0;
    st_nxt.pslverr_r = 1'b0;

    // Mode writes pass through a delay so they act two cycles after the write.
    if (st_r.mode_dly_r != 2'd0) begin // [RQ12]
      st_nxt.mode_dly_r = st_r.mode_dly_r - 2'd1;
      if (st_r.mode_dly_r == 2'd1) begin
        st_nxt.mode_act_r = st_r.mode_wr_r;
      end
    end

    // Clock source is a prescaler tap or the event pulse.
    if (st_r.mode_act_r[2:0] == PET_SEL_EVENT) begin // [RQ14]
      count_tick = ev_pulse;
    end else begin
      count_tick = ps_tick[pet_tap(st_r.mode_act_r[2:0])]; // [RQ3] [RQ9] [RQ10]
    end

    if (count_tick) begin
      if (&st_r.cnt_r) begin // [RQ6]
        st_nxt.flag_r = 1'b1; // [RQ8]
        if (st_r.mode_act_r[PET_MODE_RELOAD_BIT]) begin // [RQ7]
          st_nxt.cnt_r = {st_r.load_high_r, st_r.load_low_r};
        end else begin
          st_nxt.cnt_r = '0;
        end
      end else begin
        st_nxt.cnt_r = st_r.cnt_r + 1'b1; // [RQ4]
      end
    end

    // APB access phase; the answer comes one cycle after penable rises.
    if (access) begin
      st_nxt.pready_r = 1'b1;
      st_nxt.prdata_r = '0;
      if (pwrite) begin
        case (idx)
          PET_IDX_MODE: begin
            st_nxt.mode_wr_r  = pwdata[3:0]; // [RQ11]
            st_nxt.mode_dly_r = 2'(PET_MODE_DELAY);
          end
          PET_IDX_CNT_LOW:  st_nxt.load_low_r = pwdata[3:0]; // [RQ18] [RQ19]
          PET_IDX_CNT_HIGH: begin
            st_nxt.load_high_r = pwdata[3:0];
            hi_load            = 1'b1;
          end
          PET_IDX_PIN_FUNC: st_nxt.pin_r  = pwdata[3:0]; // [RQ15]
          PET_IDX_EDGE_SEL: st_nxt.edge_r = pwdata[1:0]; // [RQ21]
          PET_IDX_IRQ_FLAG: begin
            // A set in the same cycle wins, so only clear when no overflow arrives.
            if (!pwdata[PET_FLAG_OVF_BIT] && !(count_tick && &st_r.cnt_r)) begin
              st_nxt.flag_r = 1'b0; // [RQ8]
            end
          end
          PET_IDX_CTRL:     st_nxt.stop_r = pwdata[PET_CTRL_STOP_BIT]; // [RQ2]
          default:          st_nxt.pslverr_r = 1'b1;
        endcase
      end else begin
        case (idx)
          PET_IDX_CNT_LOW:  st_nxt.prdata_r[3:0] = st_r.low_latch_r; // [RQ20]
          PET_IDX_CNT_HIGH: begin
            st_nxt.prdata_r[3:0] = st_r.cnt_r[7:4]; // [RQ18]
            st_nxt.low_latch_r   = st_r.cnt_r[3:0]; // [RQ20]
          end
          PET_IDX_IRQ_FLAG: st_nxt.prdata_r[PET_FLAG_OVF_BIT] = st_r.flag_r;
          PET_IDX_CTRL:     st_nxt.prdata_r[PET_CTRL_STOP_BIT] = st_r.stop_r;
          PET_IDX_MODE,
          PET_IDX_PIN_FUNC,
          PET_IDX_EDGE_SEL: st_nxt.prdata_r = '0;
          default:          st_nxt.pslverr_r = 1'b1;
        endcase
      end
    end

    // Writing the high nibble loads the full start value, beating any tick.
    if (hi_load) begin
      st_nxt.cnt_r = {pwdata[3:0], st_r.load_low_r}; // [RQ5] [RQ19]
    end

    // Registered so that the pin-function output comes straight from a flip-flop.
    st_nxt.irq_en_r = st_nxt.pin_r[PET_PIN_STOPC_BIT] | st_nxt.pin_r[PET_PIN_EVENT_BIT]; // [RQ15]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r            <= '0;
      st_r.mode_wr_r  <= PET_MODE_RST;
      st_r.mode_act_r <= PET_MODE_RST; // [RQ11]
      st_r.edge_r     <= PET_EDGE_RST; // [RQ21]
      st_r.pin_r      <= PET_PIN_RST;
      st_r.load_low_r <= PET_LOAD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata              = st_r.prdata_r;
  assign pready              = st_r.pready_r;
  assign pslverr             = st_r.pslverr_r;
  assign timer_overflow_flag = st_r.flag_r;
  assign irq_pin_enable      = st_r.irq_en_r;

endmodule : pet_timer

/* File: pet_pkg.sv */
// Package with register offsets, field positions, reset values and timing constants of the timer.
package pet_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam logic [11:0] PET_IDX_MODE      = 12'h009;
  localparam logic [11:0] PET_IDX_CNT_LOW   = 12'h00a;
  localparam logic [11:0] PET_IDX_CNT_HIGH  = 12'h00b;
  localparam logic [11:0] PET_IDX_PIN_FUNC  = 12'h024;
  localparam logic [11:0] PET_IDX_EDGE_SEL  = 12'h026;
  localparam logic [11:0] PET_IDX_IRQ_FLAG  = 12'h002;
  localparam logic [11:0] PET_IDX_CTRL      = 12'h040;

  // Field positions.
  localparam int PET_MODE_RELOAD_BIT  = 3;
  localparam int PET_FLAG_OVF_BIT     = 0;
  localparam int PET_PIN_EVENT_BIT    = 0;
  localparam int PET_PIN_STOPC_BIT    = 3;
  localparam int PET_CTRL_STOP_BIT    = 0;

  // Reset values.
  localparam logic [3:0] PET_MODE_RST = 4'h0;
  localparam logic [1:0] PET_EDGE_RST = 2'h0;
  localparam logic [3:0] PET_PIN_RST  = 4'h0;
  localparam logic [3:0] PET_LOAD_RST = 4'h0;

  // Clock-select code for the external event input.
  localparam logic [2:0] PET_SEL_EVENT = 3'h7;

  // Edge-select encodings.
  localparam logic [1:0] PET_EDGE_NONE = 2'h0;
  localparam logic [1:0] PET_EDGE_FALL = 2'h1;
  localparam logic [1:0] PET_EDGE_RISE = 2'h2;
  localparam logic [1:0] PET_EDGE_BOTH = 2'h3;

  // Timing: the system clock is 10 MHz; one instruction cycle is taken as one pclk.
  localparam int PET_PCLK_HZ        = 10_000_000;
  localparam int PET_TCYC_NS        = 100;
  localparam int PET_TCYC_CYCLES    = (PET_TCYC_NS * (PET_PCLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PET_MODE_DELAY_TCYC = 2;
  localparam int PET_MODE_DELAY     = PET_MODE_DELAY_TCYC * PET_TCYC_CYCLES;

  localparam int PET_PRESCALE_W = 11;
  localparam int PET_COUNT_W    = 8;

endpackage : pet_pkg

/* File: pet_prescaler.sv */
// Free-running 11-bit prescaler with per-tap tick pulses.
`timescale 1ns/10ps
module pet_prescaler
  import pet_pkg::*;
#(
  parameter int WIDTH = PET_PRESCALE_W
) (
  // Clock and reset.
  input  wire logic             pclk,
  input  wire logic             presetn,
  // Control.
  input  wire logic             stop_mode,
  // Divider value and one-cycle tick per tap.
  output logic [WIDTH-1:0]      count,
  output logic [WIDTH-1:0]      tick
);

  typedef struct packed {
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] tick_r;
  } pet_ps_state_t;

  pet_ps_state_t st_r;
  pet_ps_state_t st_nxt;

  // Mask of a tap's lower bits; a part-select cannot follow the loop index.
  function automatic logic [WIDTH-1:0] pet_low_mask(input int k);
    logic [WIDTH-1:0] m;
    m = '0;
    for (int i = 0; i < WIDTH; i++) begin
      if (i <= k) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : pet_low_mask

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick_r = '0;
    if (!stop_mode) begin // [RQ2]
      st_nxt.cnt_r = st_r.cnt_r + 1'b1; // [RQ1]
      // A tap of period 2^(k+1) ticks when its lower bits roll over.
      for (int k = 0; k < WIDTH; k++) begin
        st_nxt.tick_r[k] = &(st_r.cnt_r | ~pet_low_mask(k));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0; // [RQ1]
    end else begin
      st_r <= st_nxt;
    end
  end

  assign count = st_r.cnt_r;
  assign tick  = st_r.tick_r;

endmodule : pet_prescaler

/* File: pet_event_sync.sv */
// Three-stage pin synchroniser with configurable edge detection.
`timescale 1ns/10ps
module pet_event_sync
  import pet_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Pin and control.
  input  wire logic       pin,
  input  wire logic       enable,
  input  wire logic [1:0] edge_sel,
  // One-cycle pulse per qualifying edge.
  output logic            event_pulse
);

  typedef struct packed {
    logic [2:0] sync_r;
    logic       level_r;
    logic       pulse_r;
  } pet_es_state_t;

  pet_es_state_t st_r;
  pet_es_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.sync_r = {st_r.sync_r[1:0], pin}; // [RQ22]
    st_nxt.pulse_r = 1'b0;
    // A change counts only once the second and third stages agree.
    if (st_r.sync_r[1] == st_r.sync_r[2] && st_r.sync_r[2] != st_r.level_r) begin
      st_nxt.level_r = st_r.sync_r[2];
      if (enable) begin // [RQ15]
        case (edge_sel) // [RQ16]
          PET_EDGE_RISE: st_nxt.pulse_r = st_r.sync_r[2];
          PET_EDGE_FALL: st_nxt.pulse_r = !st_r.sync_r[2];
          PET_EDGE_BOTH: st_nxt.pulse_r = 1'b1;
          default:       st_nxt.pulse_r = 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign event_pulse = st_r.pulse_r;

endmodule : pet_event_sync

/* File: pet_timer_properties.sv */
// Checker of the timer's bus answers and status outputs.
`timescale 1ns/10ps
module pet_timer_chk
  import pet_pkg::*;
(
  // Clock and reset.
  input wire logic        pclk,
  input wire logic        presetn,
  // Bus.
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pin and status.
  input wire logic        event_count_input,
  input wire logic        timer_overflow_flag,
  input wire logic        irq_pin_enable
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic clr_req;
  logic pin_req;
  assign clr_req = psel && pwrite && paddr == {PET_IDX_IRQ_FLAG, 2'b00} && !pwdata[0];
  assign pin_req = psel && pwrite && paddr == {PET_IDX_PIN_FUNC, 2'b00} && (pwdata[3] || pwdata[0]);
  a_ready_timing: assert property ($rose(penable) && psel |=> pready)
    else $error("pready missing");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_unmapped_error: assert property (pready && paddr == 14'h0004 |-> pslverr && prdata == 0)
    else $error("unmapped not refused");
  a_mode_unread: assert property (pready && !pwrite && paddr == {PET_IDX_MODE, 2'b00} |-> prdata == 0)
    else $error("mode readable");
  a_edge_unread: assert property (pready && !pwrite && paddr == {PET_IDX_EDGE_SEL, 2'b00} |-> prdata == 0)
    else $error("edge readable");
  a_read_width: assert property (pready |-> prdata[31:4] == 0)
    else $error("read data too wide");
  a_flag_sticky: assert property ($fell(timer_overflow_flag) |-> $past(clr_req) || $past(clr_req, 2))
    else $error("flag cleared alone");
  a_pin_enable: assert property ($rose(irq_pin_enable) |-> $past(pin_req) || $past(pin_req, 2))
    else $error("pin enabled alone");
  c_refused: cover property (pready && pslverr);
  c_overflow: cover property ($rose(timer_overflow_flag));
  c_cleared: cover property ($fell(timer_overflow_flag));
endmodule : pet_timer_chk
bind pet_timer pet_timer_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_count_input(event_count_input),
  .timer_overflow_flag(timer_overflow_flag), .irq_pin_enable(irq_pin_enable));

/* File: pet_event_src.sv */
// Event source model driving the timer's event pin.
`timescale 1ns/10ps
module pet_event_src (
  // Clock.
  input wire logic pclk,
  // Event pin.
  output logic     pin
);
  initial pin = 1'b0;
  // Each level stands at least eight cycles, far above the fall-to-rise gap.
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge pclk) pin <= 1'b1;
      repeat (8) @(posedge pclk);
      pin <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask : pulse
endmodule : pet_event_src

/* File: tb_pet_timer.sv */
// Self-checking testbench of the prescaled event timer.
`timescale 1ns/10ps
module tb_pet_timer import pet_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pin, pready, pslverr, flag, pin_en, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int          err_total, checks;
  pet_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_count_input(pin), .timer_overflow_flag(flag), .irq_pin_enable(pin_en));
  pet_event_src src (.pclk(pclk), .pin(pin));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // Holds the request until pready is sampled high, as the bus demands.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [3:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {28'h000_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic cnt_is(input logic [7:0] exp);
    logic [3:0] hi;
    apb(1'b0, PET_IDX_CNT_HIGH, 4'h0);
    hi = rd[3:0];
    apb(1'b0, PET_IDX_CNT_LOW, 4'h0);
    check({24'h00_0000, hi, rd[3:0]}, {24'h00_0000, exp});
  endtask : cnt_is
  task automatic load(input logic [7:0] v);
    apb(1'b1, PET_IDX_CNT_LOW, v[3:0]);
    apb(1'b1, PET_IDX_CNT_HIGH, v[7:4]);
  endtask : load
  task automatic t_regs();
    apb(1'b0, PET_IDX_IRQ_FLAG, 4'h0);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h001, 4'h0);
    check({31'h0000_0000, err}, 32'h0000_0001);
    apb(1'b1, PET_IDX_MODE, 4'h7);
    apb(1'b0, PET_IDX_MODE, 4'h0);
    check(rd, 32'h0000_0000);
    apb(1'b1, PET_IDX_EDGE_SEL, {2'b00, PET_EDGE_RISE});
    apb(1'b1, PET_IDX_PIN_FUNC, 4'h1);
    check({31'h0000_0000, pin_en}, 32'h0000_0001);
  endtask : t_regs
  task automatic t_load();
    load(8'ha5);
    apb(1'b1, PET_IDX_CNT_LOW, 4'h3);
    cnt_is(8'ha5);
    apb(1'b0, PET_IDX_CNT_HIGH, 4'h0);
    src.pulse(1);
    apb(1'b0, PET_IDX_CNT_LOW, 4'h0);
    check(rd, 32'h0000_0005);
    cnt_is(8'ha6);
  endtask : t_load
  task automatic t_overflow();
    for (int r = 0; r < 2; r++) begin
      apb(1'b1, PET_IDX_MODE, {r[0], PET_SEL_EVENT});
      repeat (3) @(posedge pclk);
      load(8'hfe);
      apb(1'b1, PET_IDX_IRQ_FLAG, 4'h0);
      src.pulse(1);
      check({31'h0000_0000, flag}, 32'h0000_0000);
      src.pulse(1);
      check({31'h0000_0000, flag}, 32'h0000_0001);
      apb(1'b0, PET_IDX_IRQ_FLAG, 4'h0);
      check(rd, 32'h0000_0001);
      cnt_is(r ? 8'hfe : 8'h00);
      apb(1'b1, PET_IDX_IRQ_FLAG, 4'h1);
      check({31'h0000_0000, flag}, 32'h0000_0001);
      apb(1'b1, PET_IDX_IRQ_FLAG, 4'h0);
      check({31'h0000_0000, flag}, 32'h0000_0000);
    end
  endtask : t_overflow
  task automatic t_edges();
    logic [7:0] inc [4] = '{8'h00, 8'h02, 8'h02, 8'h04};
    for (int e = 0; e < 4; e++) begin
      apb(1'b1, PET_IDX_EDGE_SEL, e[3:0]);
      load(8'h10);
      src.pulse(2);
      cnt_is(8'h10 + inc[e]);
    end
    apb(1'b1, PET_IDX_PIN_FUNC, 4'h0);
    load(8'h10);
    src.pulse(2);
    cnt_is(8'h10);
  endtask : t_edges
  task automatic t_tick();
    apb(1'b1, PET_IDX_CTRL, 4'h1);
    apb(1'b1, PET_IDX_MODE, 4'h4);
    repeat (3) @(posedge pclk);
    load(8'h00);
    repeat (20) @(posedge pclk);
    cnt_is(8'h00);
    apb(1'b1, PET_IDX_CTRL, 4'h0);
    // The prescaler runs 80 edges between the two control writes: ten ticks of period eight.
    repeat (76) @(posedge pclk);
    apb(1'b1, PET_IDX_CTRL, 4'h1);
    cnt_is(8'h0a);
  endtask : t_tick
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0000;
    pwdata = 32'h0000_0000;
    err_total = 0;
    checks = 0;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_load();
    t_overflow();
    t_edges();
    t_tick();
    stop_test();
  end
endmodule : tb_pet_timer
